// *** common/pmx_pkg.sv ***
// constants and types for the port 1 mii mux datapath
package pmx_pkg;

    // ========================================
    // port modes and heartbeat states
    typedef enum logic [1:0]
    {
        PMX_INT = 2'h0,
        PMX_MAC = 2'h1,
        PMX_PHY = 2'h3,
        PMX_RMII = 2'h2
    } pmx_mode_t;

    typedef enum logic [1:0]
    {
        PMX_HB_IDLE = 2'h0,
        PMX_HB_GAP = 2'h1,
        PMX_HB_BEAT = 2'h3
    } pmx_hb_t;

    // ========================================
    // clock rates
    localparam int CLK_KHZ = 250000;
    localparam int RATE10_KHZ = 2500;
    localparam int RATE100_KHZ = 25000;
    localparam int RATE200_KHZ = 50000;
    localparam logic [7:0] DIV_10 = 8'(CLK_KHZ / RATE10_KHZ);
    localparam logic [7:0] DIV_100 = 8'(CLK_KHZ / RATE100_KHZ);
    localparam logic [7:0] DIV_200 = 8'(CLK_KHZ / RATE200_KHZ);

    // ========================================
    // heartbeat timing, nominal figures inside the allowed windows
    localparam int HB_GAP_NS = 1000;
    localparam int HB_BEAT_NS = 1000;
    localparam int HB_GAP_CYC = HB_GAP_NS * CLK_KHZ / 1000000;
    localparam int HB_BEAT_CYC = HB_BEAT_NS * CLK_KHZ / 1000000;
    localparam logic [8:0] HB_GAP_CNT = 9'(HB_GAP_CYC - 1);
    localparam logic [8:0] HB_BEAT_CNT = 9'(HB_BEAT_CYC - 1);

    // ========================================
    // drive strength codes and synchronised pin bus layout
    localparam logic DRV_12MA = 1'b0;
    localparam logic DRV_16MA = 1'b1;
    localparam int SB_W = 10;
    localparam int SB_DV = 4;
    localparam int SB_ER = 5;
    localparam int SB_COL = 6;
    localparam int SB_CRS = 7;
    localparam int SB_OCK = 8;
    localparam int SB_ICK = 9;
    localparam logic [3:0] MSK_MII = 4'hf;
    localparam logic [3:0] MSK_RMII = 4'h3;

endpackage : pmx_pkg

// *** dv/pmx_ext_mac.sv ***
// external mac model feeding the port receive pins
`timescale 1ns/1ps
`default_nettype none

module pmx_ext_mac (
    output logic lck,
    output logic [3:0] d,
    output logic dv,
    output logic er
);
    initial
    begin
        lck = 1'b0;
        d = 4'h0;
        dv = 1'b0;
        er = 1'b0;
    end

    // ==========
    // frame sender
    // clock stands still between frames; released data shows inverted
    task send(input int n, input logic bad);
        for (int i = 0; i < n + 1; i++)
        begin
            #62.5 lck = 1'b1;
            dv = (i < n);
            d = dv ? 4'($urandom) : ~d;
            er = bad && (i == n - 1);
            #62.5 lck = 1'b0;
        end
    endtask : send
endmodule : pmx_ext_mac
`default_nettype wire

// *** dv/pmx_port_mux_tb_top.sv ***
// self-checking bench for the port mux datapath
`timescale 1ns/1ps
`default_nettype none

module pmx_port_mux_tb_top;
    // ==========
    // signals
    localparam logic [12:0] k_mac = 13'h0001, k_phy = 13'h0003,
        k_rmii = 13'h0002, k_iso = 13'h0004, k_trb = 13'h0008,
        k_lsb = 13'h0010, k_fd = 13'h0020, k_str = 13'h0040, k_hbd = 13'h0080,
        k_ct = 13'h0100, k_sct = 13'h0200, k_lb = 13'h0400,
        k_slb = 13'h0800, k_ckd = 13'h1000;
    logic sys_clk, rst, sten, coli, crsi;
    logic [12:0] cf;
    logic [3:0] stx;
    logic [9:0] irx;
    int bad_count, tests_run;
    wire [3:0] srd, itd, ptd, d;
    wire srdv, srer, scol, scrs, srck, stck, iten, ptv, ptoe, lck, dv, er;
    wire col_o, col_oe, crs_o, crs_oe, ock_o, ock_oe, ick_o, ick_oe, str;

    // ==========
    // design and far side
    pmx_port_mux pmx_port_mux_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .cfg_mode(cf[1:0]),
        .cfg_isolate(cf[2]),
        .cfg_turbo(cf[3]),
        .cfg_speed_lsb(cf[4]),
        .cfg_full_duplex(cf[5]),
        .cfg_clk_strength(cf[6]),
        .heartbeat_disable(cf[7]),
        .cfg_col_test(cf[8]),
        .cfg_sw_col_test(cf[9]),
        .cfg_loopback(cf[10]),
        .cfg_sw_loopback(cf[11]),
        .cfg_rmii_clk_dir(cf[12]),
        .sw_tx_data(stx),
        .sw_tx_en(sten),
        .sw_rx_data(srd),
        .sw_rx_dv(srdv),
        .sw_rx_er(srer),
        .sw_col(scol),
        .sw_crs(scrs),
        .sw_rx_clk(srck),
        .sw_tx_clk(stck),
        .iphy_tx_data(itd),
        .iphy_tx_en(iten),
        .iphy_rx_data(irx[3:0]),
        .iphy_rx_dv(irx[4]),
        .iphy_rx_er(irx[5]),
        .iphy_col(irx[6]),
        .iphy_crs(irx[7]),
        .iphy_rx_clk(irx[8]),
        .iphy_tx_clk(irx[9]),
        .port_tx_data_out(ptd),
        .port_tx_valid_out(ptv),
        .port_tx_oe(ptoe),
        .port_rx_data_in(d),
        .port_rx_valid_in(dv),
        .port_rx_error_in(er),
        .port_collision_pin_i(col_oe ? col_o : coli),
        .port_collision_pin_o(col_o),
        .port_collision_pin_oe(col_oe),
        .port_carrier_pin_i(crs_oe ? crs_o : crsi),
        .port_carrier_pin_o(crs_o),
        .port_carrier_pin_oe(crs_oe),
        .port_out_clock_pin_i(ock_oe ? ock_o : lck),
        .port_out_clock_pin_o(ock_o),
        .port_out_clock_pin_oe(ock_oe),
        .port_in_clock_pin_i(ick_oe ? ick_o : lck),
        .port_in_clock_pin_o(ick_o),
        .port_in_clock_pin_oe(ick_oe),
        .clk_strength_16ma(str)
    );
    pmx_ext_mac pmx_ext_mac_inst (
        .lck(lck),
        .d(d),
        .dv(dv),
        .er(er)
    );

    // ==========
    // tasks
    task final_report();
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // four edges cover the two sync flops plus the output register
    task go(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : go
    task setc(input logic [12:0] v);
        @(posedge sys_clk);
        cf <= v;
        go(4);
    endtask : setc
    task drive(input logic en, input logic [3:0] v);
        @(posedge sys_clk);
        sten <= en;
        stx <= v;
        go(4);
    endtask : drive
    task rnd();
        @(posedge sys_clk);
        stx <= 4'($urandom);
        sten <= 1'($urandom);
        irx <= 10'($urandom);
        coli <= 1'($urandom);
        crsi <= 1'($urandom);
        go(4);
    endtask : rnd
    function automatic logic near(input int c, input int e);
        return c >= e - 1 && c <= e + 1;
    endfunction : near
    task rate(input int e);
        int c0, c1, c2;
        logic [2:0] p;
        c0 = 0;
        c1 = 0;
        c2 = 0;
        p = {ock_o, ick_o, srck};
        for (int i = 0; i < 1000; i++)
        begin
            go(1);
            c0 += int'(ock_o && !p[2]);
            c1 += int'(ick_o && !p[1]);
            c2 += int'(srck && !p[0]);
            p = {ock_o, ick_o, srck};
        end
        chk({near(c0, e), near(c1, e), near(c2, e)}, 3'h7);
    endtask : rate
    task spd(input logic [12:0] v, input int e, input logic s);
        setc(v);
        rate(e);
        chk(str, s);
    endtask : spd
    task frame(input int n, input int k);
        fork
            pmx_ext_mac_inst.send(n, k == 1);
            repeat (n)
            begin
                @(negedge lck);
                #30;
                if (k == 0) chk({srd, srdv, crs_o}, {d, 2'b11});
                if (k == 1) chk({srd, srdv, srer, srck, stck}, {d, 1'b1, er, lck, lck});
                if (k == 2) chk({ptd, ptv, srdv, crs_o, col_o}, {d, 4'ha});
                if (k == 3) chk(col_o, 1'b1);
                if (k == 4) chk({srdv, scrs}, 2'b00);
                if (k == 5) chk({srd[1:0], srdv, srck, col_o}, {d[1:0], 1'b1, lck, 1'b0});
            end
        join
    endtask : frame
    // window counted from the fall, about 16 cycles before the end of frame
    task hb(input logic on);
        int t0, t1;
        t0 = 0;
        t1 = 0;
        for (int i = 0; i < 900; i++)
        begin
            go(1);
            if (col_o && t1 == 0)
                t0 = i + 16;
            if (col_o)
                t1++;
        end
        chk(t0 >= 150 && t0 <= 400 && t1 >= 125 && t1 <= 375, on);
    endtask : hb

    // ==========
    // tests
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end
    initial
    begin
        {rst, cf, stx, sten, irx, coli, crsi} = {1'b1, 30'h0000_0000};
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'h6bae));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        setc(13'h0000);
        repeat (12) begin rnd(); chk({itd, iten, scrs, scol, srer, srdv, srd}, {stx, sten, irx[7:0]}); end
        setc(k_mac);
        repeat (12) begin rnd(); chk({ptd, ptv, ptoe, scol, scrs, col_oe, crs_oe, str}, {stx, sten, 1'b1, coli, crsi, 3'h0}); end
        frame(6, 1);
        setc(k_phy);
        repeat (12) begin rnd(); chk({ptd, ptv, crs_o, scrs, col_oe, crs_oe, ick_oe, ock_oe}, {stx, sten, sten, sten, 4'hf}); end
        spd(k_phy, 10, 1'b0);
        spd(k_phy | k_lsb, 100, 1'b0);
        spd(k_phy | k_lsb | k_trb, 200, 1'b0);
        spd(k_phy | k_lsb | k_trb | k_str, 200, 1'b1);
        spd(k_phy | k_trb | k_str, 10, 1'b0);
        drive(1'b0, 4'h0);
        setc(k_phy);
        frame(6, 0);
        hb(1'b1);
        setc(k_phy | k_hbd);
        frame(6, 0);
        hb(1'b0);
        setc(k_phy | k_fd);
        frame(6, 0);
        hb(1'b0);
        setc(k_phy | k_ct);
        frame(5, 3);
        setc(k_phy | k_lb);
        drive(1'b1, 4'h5);
        chk({ptv, crs_o, col_o, scrs}, 4'h1);
        frame(6, 2);
        hb(1'b0);
        setc(k_phy | k_lb | k_ct);
        frame(4, 3);
        setc(k_phy | k_iso | k_sct);
        chk({ptoe, col_oe, crs_oe, ick_oe, ock_oe, scol}, 6'h01);
        drive(1'b0, 4'h0);
        frame(4, 4);
        setc(k_phy | k_slb | k_iso);
        repeat (8) begin rnd(); chk({srd, srdv, scrs, scol, ptv}, {stx, sten, sten, 2'b00}); end
        setc(k_phy | k_slb | k_sct);
        drive(1'b0, 4'h0);
        frame(4, 4);
        setc(k_rmii | k_ckd | k_str | k_ct | k_sct);
        drive(1'b1, 4'hf);
        chk({ptd, ock_oe, str, col_oe, crs_oe, scol}, 9'h079);
        rate(200);
        drive(1'b0, 4'h0);
        setc(k_rmii | k_ct);
        chk(ock_oe, 1'b0);
        frame(6, 5);
        hb(1'b0);
        final_report();
    end
endmodule : pmx_port_mux_tb_top
`default_nettype wire

// *** rtl/pmx_port_mux.sv ***
// port 1 mii mux datapath: internal, mii mac, mii phy and rmii phy modes
//
// How it works
// - internal mode wires switch mac to internal phy
// - mac mode drives pins, takes inputs from pins
// - phy mode makes clocks, carrier and collision
// - isolate tristates pins bar the rmii ref out, and ignores mac inputs in phy
// - turbo raises emulated phy rate from 100 to 200
// - with turbo, speed bit picks 10 or 200
// - turbo at 200 clock strength follows control, else 12ma outside rmii ref out
// - heartbeat pulse after tx end, 10 half duplex
// - heartbeat disable suppresses the heartbeat pulse
// - external collision test echoes mac transmit
// - switch collision test echoes switch transmit
// - external loopback returns mac data to pins
// - external loopback collision only from test bit
// - external loopback carrier from mac transmit only
// - switch loopback returns switch data internally
// - switch loopback collision test, carrier from switch
// - rmii uses two data bits, valids, ref clock
// - rmii clock direction picks pin or internal ref
// - rmii output ref strength follows strength control
// - rmii never makes heartbeat
// - rmii ignores external collision test
`timescale 1ns/1ps
`default_nettype none

module pmx_port_mux (
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_isolate,
    input wire logic cfg_turbo,
    input wire logic cfg_speed_lsb,
    input wire logic cfg_full_duplex,
    input wire logic cfg_clk_strength,
    input wire logic heartbeat_disable,
    input wire logic cfg_col_test,
    input wire logic cfg_sw_col_test,
    input wire logic cfg_loopback,
    input wire logic cfg_sw_loopback,
    input wire logic cfg_rmii_clk_dir,
    // switch fabric mac
    input wire logic [3:0] sw_tx_data,
    input wire logic sw_tx_en,
    output logic [3:0] sw_rx_data,
    output logic sw_rx_dv,
    output logic sw_rx_er,
    output logic sw_col,
    output logic sw_crs,
    output logic sw_rx_clk,
    output logic sw_tx_clk,
    // internal phy
    output logic [3:0] iphy_tx_data,
    output logic iphy_tx_en,
    input wire logic [3:0] iphy_rx_data,
    input wire logic iphy_rx_dv,
    input wire logic iphy_rx_er,
    input wire logic iphy_col,
    input wire logic iphy_crs,
    input wire logic iphy_rx_clk,
    input wire logic iphy_tx_clk,
    // pins
    output logic [3:0] port_tx_data_out,
    output logic port_tx_valid_out,
    output logic port_tx_oe,
    input wire logic [3:0] port_rx_data_in,
    input wire logic port_rx_valid_in,
    input wire logic port_rx_error_in,
    input wire logic port_collision_pin_i,
    output logic port_collision_pin_o,
    output logic port_collision_pin_oe,
    input wire logic port_carrier_pin_i,
    output logic port_carrier_pin_o,
    output logic port_carrier_pin_oe,
    input wire logic port_out_clock_pin_i,
    output logic port_out_clock_pin_o,
    output logic port_out_clock_pin_oe,
    input wire logic port_in_clock_pin_i,
    output logic port_in_clock_pin_o,
    output logic port_in_clock_pin_oe,
    output logic clk_strength_16ma
);

    // ========================================
    // pin synchronisers
    logic [pmx_pkg::SB_W-1:0] pin_raw;
    logic [pmx_pkg::SB_W-1:0] pin_s;

    assign pin_raw = {port_in_clock_pin_i, port_out_clock_pin_i,
                      port_carrier_pin_i, port_collision_pin_i,
                      port_rx_error_in, port_rx_valid_in,
                      port_rx_data_in};

    pmx_sync #(.W(pmx_pkg::SB_W)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(pin_raw),
        .q(pin_s)
    );

    // ========================================
    // mode decode
    pmx_pkg::pmx_mode_t mode;
    wire is_int;
    wire is_mac;
    wire is_phy;
    wire is_rmii;
    wire phy_any;
    wire iso;
    wire sw_lb;
    wire ext_lb;
    wire normal;
    wire turbo_rate;
    wire slow_rate;
    wire [3:0] msk;

    assign mode = pmx_pkg::pmx_mode_t'(cfg_mode);
    assign is_int = mode == pmx_pkg::PMX_INT;
    assign is_mac = mode == pmx_pkg::PMX_MAC;
    assign is_phy = mode == pmx_pkg::PMX_PHY;
    assign is_rmii = mode == pmx_pkg::PMX_RMII;
    assign phy_any = is_phy | is_rmii;
    assign iso = phy_any & cfg_isolate;
    // switch loopback wins when both loopbacks are set
    assign sw_lb = phy_any & cfg_sw_loopback;
    assign ext_lb = phy_any & cfg_loopback & ~sw_lb;
    assign normal = ~sw_lb & ~ext_lb;
    assign turbo_rate = is_phy & cfg_turbo & cfg_speed_lsb;
    assign slow_rate = is_phy & ~cfg_speed_lsb;
    assign msk = is_rmii ? pmx_pkg::MSK_RMII : pmx_pkg::MSK_MII;

    // ========================================
    // inputs from the external mac, blanked when isolated
    wire ext_tx;
    wire ext_er;
    wire [3:0] ext_d;

    assign ext_tx = pin_s[pmx_pkg::SB_DV] & ~iso;
    assign ext_er = pin_s[pmx_pkg::SB_ER] & ~iso;
    assign ext_d = iso ? 4'h0 : (pin_s[3:0] & msk);

    // ========================================
    // emulated phy clock divider
    logic [7:0] div_cnt_r;
    logic [7:0] div_cnt_nxt;
    logic div_clk_r;
    logic div_clk_nxt;
    wire [7:0] div_per;

    // rmii reference and turbo share the 50 MHz divide
    assign div_per = (is_rmii | turbo_rate) ? pmx_pkg::DIV_200 :
                     slow_rate ? pmx_pkg::DIV_10 : pmx_pkg::DIV_100;
    // a shortened period after a rate change wraps at once
    assign div_cnt_nxt = (div_cnt_r >= div_per - 8'h01) ? 8'h00 :
                         div_cnt_r + 8'h01;
    assign div_clk_nxt = div_cnt_nxt < (div_per >> 1);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_r <= 8'h00;
            div_clk_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            div_clk_r <= div_clk_nxt;
        end
    end

    // rmii reference: sampled pin or own divider
    wire ref_clk;
    assign ref_clk = cfg_rmii_clk_dir ? div_clk_r :
                     pin_s[pmx_pkg::SB_OCK];

    // ========================================
    // heartbeat sequencer
    pmx_pkg::pmx_hb_t hb_st_r;
    pmx_pkg::pmx_hb_t hb_st_nxt;
    logic [8:0] hb_cnt_r;
    logic [8:0] hb_cnt_nxt;
    logic ext_tx_d_r;
    wire hb_ok;
    wire ext_fall;
    wire hb_beat;

    // rmii never qualifies, so the disable bit is moot there
    assign hb_ok = is_phy & slow_rate & ~cfg_full_duplex &
                   ~heartbeat_disable;
    assign ext_fall = ext_tx_d_r & ~ext_tx;
    assign hb_beat = hb_st_r == pmx_pkg::PMX_HB_BEAT;

    always_comb
    begin
        hb_st_nxt = hb_st_r;
        hb_cnt_nxt = hb_cnt_r;
        case (hb_st_r)
            pmx_pkg::PMX_HB_IDLE:
            begin
                if (ext_fall)
                begin
                    hb_st_nxt = pmx_pkg::PMX_HB_GAP;
                    hb_cnt_nxt = pmx_pkg::HB_GAP_CNT;
                end
            end
            pmx_pkg::PMX_HB_GAP:
            begin
                if (hb_cnt_r == 9'h000)
                begin
                    hb_st_nxt = pmx_pkg::PMX_HB_BEAT;
                    hb_cnt_nxt = pmx_pkg::HB_BEAT_CNT;
                end
                else
                begin
                    hb_cnt_nxt = hb_cnt_r - 9'h001;
                end
            end
            pmx_pkg::PMX_HB_BEAT:
            begin
                if (hb_cnt_r == 9'h000)
                begin
                    hb_st_nxt = pmx_pkg::PMX_HB_IDLE;
                end
                else
                begin
                    hb_cnt_nxt = hb_cnt_r - 9'h001;
                end
            end
            default:
            begin
                hb_st_nxt = pmx_pkg::PMX_HB_IDLE;
            end
        endcase
        if (!hb_ok)
        begin
            hb_st_nxt = pmx_pkg::PMX_HB_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hb_st_r <= pmx_pkg::PMX_HB_IDLE;
            hb_cnt_r <= 9'h000;
            ext_tx_d_r <= 1'b0;
        end
        else
        begin
            hb_st_r <= hb_st_nxt;
            hb_cnt_r <= hb_cnt_nxt;
            ext_tx_d_r <= ext_tx;
        end
    end

    // ========================================
    // pin side next values
    wire [3:0] ptx_d_nxt;
    wire ptx_v_nxt;
    wire ptx_oe_nxt;
    wire pcol_nxt;
    wire pcrs_nxt;
    wire phy_oe_nxt;
    wire ock_oe_nxt;
    wire drv_nxt;

    assign ptx_d_nxt = is_mac ? sw_tx_data :
                       ext_lb ? ext_d :
                       (phy_any & ~sw_lb) ? (sw_tx_data & msk) :
                       4'h0;
    assign ptx_v_nxt = is_mac ? sw_tx_en :
                       ext_lb ? ext_tx :
                       (phy_any & ~sw_lb) & sw_tx_en;
    assign ptx_oe_nxt = is_mac | (phy_any & ~cfg_isolate);
    // switch side traffic never reaches the pins in either loopback
    assign pcol_nxt = is_phy & ((cfg_col_test & ext_tx) |
                      (normal & ~cfg_full_duplex & ext_tx & sw_tx_en) |
                      (~ext_lb & hb_beat));
    assign pcrs_nxt = is_phy & (ext_tx | (normal & sw_tx_en));
    assign phy_oe_nxt = is_phy & ~cfg_isolate;
    // the rmii reference keeps running under isolate: others clock from it
    assign ock_oe_nxt = phy_oe_nxt | (is_rmii & cfg_rmii_clk_dir);
    assign drv_nxt = (turbo_rate | (is_rmii & cfg_rmii_clk_dir)) ?
                     cfg_clk_strength : pmx_pkg::DRV_12MA;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            port_tx_data_out <= 4'h0;
            port_tx_valid_out <= 1'b0;
            port_tx_oe <= 1'b0;
            port_collision_pin_o <= 1'b0;
            port_collision_pin_oe <= 1'b0;
            port_carrier_pin_o <= 1'b0;
            port_carrier_pin_oe <= 1'b0;
            port_out_clock_pin_o <= 1'b0;
            port_out_clock_pin_oe <= 1'b0;
            port_in_clock_pin_o <= 1'b0;
            port_in_clock_pin_oe <= 1'b0;
            clk_strength_16ma <= pmx_pkg::DRV_12MA;
        end
        else
        begin
            port_tx_data_out <= ptx_d_nxt;
            port_tx_valid_out <= ptx_v_nxt;
            port_tx_oe <= ptx_oe_nxt;
            port_collision_pin_o <= pcol_nxt;
            port_collision_pin_oe <= phy_oe_nxt;
            port_carrier_pin_o <= pcrs_nxt;
            port_carrier_pin_oe <= phy_oe_nxt;
            port_out_clock_pin_o <= div_clk_nxt;
            port_out_clock_pin_oe <= ock_oe_nxt;
            port_in_clock_pin_o <= div_clk_nxt;
            port_in_clock_pin_oe <= phy_oe_nxt;
            clk_strength_16ma <= drv_nxt;
        end
    end

    // ========================================
    // switch side next values
    wire [3:0] srx_d_nxt;
    wire srx_dv_nxt;
    wire srx_er_nxt;
    wire scol_nxt;
    wire scrs_nxt;
    wire srxc_nxt;
    wire stxc_nxt;
    wire phy_clk;

    assign phy_clk = is_rmii ? ref_clk : div_clk_r;
    assign srx_d_nxt = is_int ? iphy_rx_data :
                       is_mac ? pin_s[3:0] :
                       sw_lb ? sw_tx_data :
                       (phy_any & normal) ? ext_d : 4'h0;
    assign srx_dv_nxt = is_int ? iphy_rx_dv :
                        is_mac ? pin_s[pmx_pkg::SB_DV] :
                        sw_lb ? sw_tx_en :
                        phy_any & normal & ext_tx;
    assign srx_er_nxt = is_int ? iphy_rx_er :
                        is_mac ? pin_s[pmx_pkg::SB_ER] :
                        phy_any & normal & ext_er;
    // collision test ignores isolate on purpose
    assign scol_nxt = is_int ? iphy_col :
                      is_mac ? pin_s[pmx_pkg::SB_COL] :
                      (cfg_sw_col_test & sw_tx_en) |
                      (is_phy & normal & ~cfg_full_duplex &
                       ext_tx & sw_tx_en);
    assign scrs_nxt = is_int ? iphy_crs :
                      is_mac ? pin_s[pmx_pkg::SB_CRS] :
                      sw_tx_en | (normal & ext_tx);
    assign srxc_nxt = is_int ? iphy_rx_clk :
                      is_mac ? pin_s[pmx_pkg::SB_ICK] : phy_clk;
    assign stxc_nxt = is_int ? iphy_tx_clk :
                      is_mac ? pin_s[pmx_pkg::SB_OCK] : phy_clk;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sw_rx_data <= 4'h0;
            sw_rx_dv <= 1'b0;
            sw_rx_er <= 1'b0;
            sw_col <= 1'b0;
            sw_crs <= 1'b0;
            sw_rx_clk <= 1'b0;
            sw_tx_clk <= 1'b0;
            iphy_tx_data <= 4'h0;
            iphy_tx_en <= 1'b0;
        end
        else
        begin
            sw_rx_data <= srx_d_nxt;
            sw_rx_dv <= srx_dv_nxt;
            sw_rx_er <= srx_er_nxt;
            sw_col <= scol_nxt;
            sw_crs <= scrs_nxt;
            sw_rx_clk <= srxc_nxt;
            sw_tx_clk <= stxc_nxt;
            iphy_tx_data <= is_int ? sw_tx_data : 4'h0;
            iphy_tx_en <= is_int & sw_tx_en;
        end
    end

    // ========================================
    // assertions
    localparam int HB_G = pmx_pkg::HB_GAP_CYC;
    localparam int HB_B = pmx_pkg::HB_BEAT_CYC;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_int_path;
        is_int && $past(is_int) |-> iphy_tx_en == $past(sw_tx_en);
    endproperty
    a_int_path: assert property (p_int_path)
        else $error("internal phy tx enable mismatch");

    property p_mac_path;
        is_mac && $past(is_mac) |->
            port_tx_valid_out == $past(sw_tx_en) && port_tx_oe &&
            !port_collision_pin_oe;
    endproperty
    a_mac_path: assert property (p_mac_path)
        else $error("mac mode pin drive wrong");

    property p_phy_oe;
        is_phy && !cfg_isolate ##1 is_phy && !cfg_isolate |->
            port_carrier_pin_oe && port_in_clock_pin_oe;
    endproperty
    a_phy_oe: assert property (p_phy_oe)
        else $error("phy mode pins not driven");

    property p_isolate;
        // switch loopback keeps running under isolate
        iso ##1 iso |-> !port_tx_oe &&
            sw_rx_dv == $past(sw_lb && sw_tx_en);
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("isolate left pins driven");

    // losing the qualifying config cuts the beat short on purpose
    property p_beat_len;
        disable iff (rst || !hb_ok)
        $rose(hb_beat) |-> ##(HB_B - 1) hb_beat ##1 !hb_beat;
    endproperty
    a_beat_len: assert property (p_beat_len)
        else $error("heartbeat length wrong");

    property p_beat_gap;
        $rose(hb_beat) |-> $past(ext_fall, HB_G + 1);
    endproperty
    a_beat_gap: assert property (p_beat_gap)
        else $error("heartbeat gap wrong");

    property p_hb_off;
        (heartbeat_disable || is_rmii) |=> !hb_beat;
    endproperty
    a_hb_off: assert property (p_hb_off)
        else $error("heartbeat while disabled");

    property p_ext_col;
        is_phy && cfg_col_test && ext_tx |=> port_collision_pin_o;
    endproperty
    a_ext_col: assert property (p_ext_col)
        else $error("external collision test missed");

    property p_sw_col;
        phy_any && cfg_sw_col_test && sw_tx_en |=> sw_col;
    endproperty
    a_sw_col: assert property (p_sw_col)
        else $error("switch collision test missed");

    property p_sw_lb;
        sw_lb |=> !port_tx_valid_out && sw_rx_dv == $past(sw_tx_en);
    endproperty
    a_sw_lb: assert property (p_sw_lb)
        else $error("switch loopback leaked");

    property p_drv;
        !turbo_rate && !is_rmii |=> clk_strength_16ma == pmx_pkg::DRV_12MA;
    endproperty
    a_drv: assert property (p_drv)
        else $error("drive strength not forced low");

    c_beat: cover property ($rose(hb_beat));
    c_ext_lb: cover property (ext_lb && ext_tx);
    c_sw_lb: cover property (sw_lb && sw_tx_en);
    c_turbo: cover property (turbo_rate && clk_strength_16ma);

endmodule : pmx_port_mux

`default_nettype wire

// *** rtl/pmx_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pmx_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // first stage is read only by the second stage
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : pmx_sync

`default_nettype wire
